// ---- include/tidu_pkg.sv ----
// Purpose: shared constants for the transfer-information decode and update block
// Assumes: fields packed as they sit in the two mode bytes of a fetched set
// Notes:   positions are bit indices within their byte
package tidu_pkg;
    // ----------------------------------------
    // widths
    // ----------------------------------------
    localparam int ADDR_W  = 24;
    localparam int COUNT_W = 16;
    localparam int BYTE_W  = 8;
    // ----------------------------------------
    // mode byte a fields
    // ----------------------------------------
    localparam int SRC_STEP_HI_POS = 7;
    localparam int SRC_STEP_LO_POS = 6;
    localparam int DST_STEP_HI_POS = 5;
    localparam int DST_STEP_LO_POS = 4;
    localparam int MODE_SEL_HI_POS = 3;
    localparam int MODE_SEL_LO_POS = 2;
    localparam int REPEAT_SIDE_POS = 1;
    localparam int SIZE_SEL_POS    = 0;
    // ----------------------------------------
    // mode byte b fields
    // ----------------------------------------
    localparam int CHAIN_EN_POS    = 7;
    localparam int IRQ_EACH_POS    = 6;
    // ----------------------------------------
    // codes and steps
    // ----------------------------------------
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_REPEAT = 2'h1;
    localparam logic [1:0] MODE_BLOCK  = 2'h2;
    localparam logic [1:0] MODE_UNUSED = 2'h3;
    localparam logic [ADDR_W-1:0] STEP_BYTE = 24'h00_0001;
    localparam logic [ADDR_W-1:0] STEP_WORD = 24'h00_0002;
    localparam logic [COUNT_W-1:0] COUNT_ONE = 16'h0001;
    localparam logic [BYTE_W-1:0]  LOW_ONE   = 8'h01;
    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [ADDR_W-1:0]  ADDR_RST  = 24'h00_0000;
    localparam logic [COUNT_W-1:0] COUNT_RST = 16'h0000;
    localparam logic [BYTE_W-1:0]  BYTE_RST  = 8'h00;
endpackage

// ---- rtl/tidu_addr_step.sv ----
// Purpose: next address for one side after a transfer
// Assumes: span is the repeat area length in transfers, 0 meaning 256
// Notes:   restore rewinds the area to its start at its last transfer
`timescale 1ns/100ps
`default_nettype none
module tidu_addr_step #(
    parameter int ADDR_W = 24
) (
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic              step_hi,
    input  wire logic              step_lo,
    input  wire logic              word,
    input  wire logic              restore,
    input  wire logic [7:0]        span,
    output logic      [ADDR_W-1:0] addr_next
);
    logic [ADDR_W-1:0] step;
    logic [ADDR_W-1:0] back;
    logic [8:0]        n;

    always_comb begin
        step = word ? ADDR_W'(tidu_pkg::STEP_WORD) : ADDR_W'(tidu_pkg::STEP_BYTE);
        n    = (span == 8'h00) ? 9'h100 : {1'b0, span};
        // whole area length, span times the step size, so restore lands on the start
        back = word ? ADDR_W'({n, 1'b0}) : ADDR_W'(n);
        if (!step_hi) begin
            addr_next = addr;
        end else if (!step_lo) begin
            addr_next = restore ? addr + step - back : addr + step;
        end else begin
            addr_next = restore ? addr - step + back : addr - step;
        end
    end
endmodule
`default_nettype wire

// ---- rtl/tidu_core.sv ----
// Purpose: decode a fetched transfer-information set and compute its write-back
// Assumes: sequencer fetches the set from on-chip ram and writes it back itself
// Notes:   one update per load; a chain or a new activation needs a fresh load
// Notes on behaviour
// - source address fixed, incremented or decremented by 1 or 2 after transfer
// - destination address fixed, incremented or decremented by 1 or 2 likewise
// - mode field: 00 normal, 01 repeat, 10 block, 11 unassigned
// - repeat side select 0 means destination area, 1 means source area
// - size select 0 moves a byte, 1 moves a 16-bit word
// - chain set fetches next set in same activation, else back to waiting
// - chained transfer: no end check, no source flag clear, no enable clear
// - irq select 0 clears source flag unless counter reached zero
// - irq select 1 leaves source flag set so cpu interrupt is raised
// - normal mode: whole primary count decrements, sequence ends at zero
// - repeat or block: low byte decrements, reloads from high byte at zero
// - block mode: block count decrements per block, sequence ends at zero
// - set lives in on-chip ram, not reachable as device registers
`timescale 1ns/100ps
`default_nettype none
module tidu_core #(
    parameter int ADDR_W  = 24,
    parameter int COUNT_W = 16
) (
    input  wire logic               mclk,
    input  wire logic               rst,
    input  wire logic               info_load,
    input  wire logic [7:0]         transfer_mode_byte_a,
    input  wire logic [7:0]         transfer_mode_byte_b,
    input  wire logic [ADDR_W-1:0]  source_address,
    input  wire logic [ADDR_W-1:0]  destination_address,
    input  wire logic [COUNT_W-1:0] transfer_count_primary,
    input  wire logic [COUNT_W-1:0] transfer_count_block,
    input  wire logic               xfer_done,
    output logic                    info_ready,
    output logic                    size_word,
    output logic                    repeat_area_is_source,
    output logic [1:0]              mode_eff,
    output logic                    wb_valid,
    output logic [ADDR_W-1:0]       wb_source_address,
    output logic [ADDR_W-1:0]       wb_destination_address,
    output logic [COUNT_W-1:0]      wb_count_primary,
    output logic [COUNT_W-1:0]      wb_count_block,
    output logic                    chain_fetch,
    output logic                    finish_wait,
    output logic                    seq_end,
    output logic                    clear_source_flag,
    output logic                    clear_activation_enable
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b01,
        ST_READY = 2'b10
    } tidu_state_e;

    tidu_state_e        st_reg, st_next;
    logic [7:0]         ma_reg, ma_next;
    logic [1:0]         md_reg, md_next;
    logic               chain_reg, chain_next, irq_reg, irq_next;
    logic [ADDR_W-1:0]  sa_reg, sa_next, da_reg, da_next;
    logic [COUNT_W-1:0] ca_reg, ca_next, cb_reg, cb_next;
    logic               wbv_reg, wbv_next, chn_reg, chn_next, fin_reg, fin_next;
    logic               end_reg, end_next, clf_reg, clf_next, cle_reg, cle_next;

    // ----------------------------------------
    // decode
    // ----------------------------------------
    function automatic logic [1:0] eff_mode(input logic [7:0] ma);
        logic [1:0] m;
        m = {ma[tidu_pkg::MODE_SEL_HI_POS], ma[tidu_pkg::MODE_SEL_LO_POS]};
        eff_mode = (m == tidu_pkg::MODE_UNUSED) ? tidu_pkg::MODE_NORMAL : m;
    endfunction

    logic [1:0] mode;
    logic       word, rpt_src, area_mode, low_end, src_rst, dst_rst;
    logic [7:0] low_dec;
    logic [ADDR_W-1:0] sa_step, da_step;

    always_comb begin
        mode      = md_reg;
        word      = ma_reg[tidu_pkg::SIZE_SEL_POS];
        rpt_src   = ma_reg[tidu_pkg::REPEAT_SIDE_POS];
        area_mode = (mode != tidu_pkg::MODE_NORMAL);
        low_dec   = ca_reg[7:0] - tidu_pkg::LOW_ONE;
        low_end   = area_mode && (low_dec == tidu_pkg::BYTE_RST);
        src_rst   = low_end && rpt_src;
        dst_rst   = low_end && !rpt_src;
    end

    tidu_addr_step #(.ADDR_W(ADDR_W)) u_src_step (
        .addr      (sa_reg),
        .step_hi   (ma_reg[tidu_pkg::SRC_STEP_HI_POS]),
        .step_lo   (ma_reg[tidu_pkg::SRC_STEP_LO_POS]),
        .word      (word),
        .restore   (src_rst),
        .span      (ca_reg[15:8]),
        .addr_next (sa_step)
    );

    tidu_addr_step #(.ADDR_W(ADDR_W)) u_dst_step (
        .addr      (da_reg),
        .step_hi   (ma_reg[tidu_pkg::DST_STEP_HI_POS]),
        .step_lo   (ma_reg[tidu_pkg::DST_STEP_LO_POS]),
        .word      (word),
        .restore   (dst_rst),
        .span      (ca_reg[15:8]),
        .addr_next (da_step)
    );

    // ----------------------------------------
    // next state
    // ----------------------------------------
    logic done_cnt;

    always_comb begin
        st_next    = st_reg;
        ma_next    = ma_reg;
        md_next    = md_reg;
        chain_next = chain_reg;
        irq_next   = irq_reg;
        sa_next    = sa_reg;
        da_next    = da_reg;
        ca_next    = ca_reg;
        cb_next    = cb_reg;
        wbv_next   = 1'b0;
        chn_next   = 1'b0;
        fin_next   = 1'b0;
        end_next   = 1'b0;
        clf_next   = 1'b0;
        cle_next   = 1'b0;
        done_cnt   = 1'b0;
        case (st_reg)
            ST_IDLE: begin
                if (info_load) begin
                    // low six bits of byte b never stored: no effect on operation
                    ma_next    = transfer_mode_byte_a;
                    md_next    = eff_mode(transfer_mode_byte_a);
                    chain_next = transfer_mode_byte_b[tidu_pkg::CHAIN_EN_POS];
                    irq_next   = transfer_mode_byte_b[tidu_pkg::IRQ_EACH_POS];
                    sa_next    = source_address;
                    da_next    = destination_address;
                    ca_next    = transfer_count_primary;
                    cb_next    = transfer_count_block;
                    st_next    = ST_READY;
                end
            end
            ST_READY: begin
                if (xfer_done) begin
                    sa_next = sa_step;
                    da_next = da_step;
                    case (mode)
                        tidu_pkg::MODE_NORMAL: begin
                            ca_next  = ca_reg - tidu_pkg::COUNT_ONE;
                            done_cnt = (ca_next == tidu_pkg::COUNT_RST);
                        end
                        tidu_pkg::MODE_REPEAT: begin
                            ca_next = {ca_reg[15:8], low_end ? ca_reg[15:8] : low_dec};
                        end
                        tidu_pkg::MODE_BLOCK: begin
                            ca_next = {ca_reg[15:8], low_end ? ca_reg[15:8] : low_dec};
                            if (low_end) begin
                                cb_next  = cb_reg - tidu_pkg::COUNT_ONE;
                                done_cnt = (cb_next == tidu_pkg::COUNT_RST);
                            end
                        end
                        default: begin
                            ca_next = ca_reg;
                        end
                    endcase
                    wbv_next = 1'b1;
                    if (chain_reg) begin
                        chn_next = 1'b1;
                    end else begin
                        fin_next = 1'b1;
                        end_next = done_cnt;
                        clf_next = !irq_reg && !done_cnt;
                        cle_next = done_cnt || irq_reg;
                    end
                    st_next = ST_IDLE;
                end
            end
            default: begin
                st_next = ST_IDLE;
            end
        endcase
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            st_reg    <= ST_IDLE;
            ma_reg    <= tidu_pkg::BYTE_RST;
            md_reg    <= tidu_pkg::MODE_NORMAL;
            chain_reg <= 1'b0;
            irq_reg   <= 1'b0;
            sa_reg    <= tidu_pkg::ADDR_RST;
            da_reg    <= tidu_pkg::ADDR_RST;
            ca_reg    <= tidu_pkg::COUNT_RST;
            cb_reg    <= tidu_pkg::COUNT_RST;
            wbv_reg   <= 1'b0;
            chn_reg   <= 1'b0;
            fin_reg   <= 1'b0;
            end_reg   <= 1'b0;
            clf_reg   <= 1'b0;
            cle_reg   <= 1'b0;
        end else begin
            st_reg    <= st_next;
            ma_reg    <= ma_next;
            md_reg    <= md_next;
            chain_reg <= chain_next;
            irq_reg   <= irq_next;
            sa_reg    <= sa_next;
            da_reg    <= da_next;
            ca_reg    <= ca_next;
            cb_reg    <= cb_next;
            wbv_reg   <= wbv_next;
            chn_reg   <= chn_next;
            fin_reg   <= fin_next;
            end_reg   <= end_next;
            clf_reg   <= clf_next;
            cle_reg   <= cle_next;
        end
    end

    // set only enters through the load port; nothing here is software-addressable
    // ready is the one-hot bit of its state, so the port comes straight from a flop
    assign info_ready              = st_reg[1];
    assign size_word               = ma_reg[tidu_pkg::SIZE_SEL_POS];
    assign repeat_area_is_source   = ma_reg[tidu_pkg::REPEAT_SIDE_POS];
    assign mode_eff                = md_reg;
    assign wb_valid                = wbv_reg;
    assign wb_source_address       = sa_reg;
    assign wb_destination_address  = da_reg;
    assign wb_count_primary        = ca_reg;
    assign wb_count_block          = cb_reg;
    assign chain_fetch             = chn_reg;
    assign finish_wait             = fin_reg;
    assign seq_end                 = end_reg;
    assign clear_source_flag       = clf_reg;
    assign clear_activation_enable = cle_reg;
endmodule
`default_nettype wire

// ---- sim/tidu_core_asserts.sv ----
// Purpose: port-level checks on the transfer-information update block
// Assumes: single clock domain, sync reset
// Notes:   step checks only in normal mode, where no area rewind applies
`timescale 1ns/100ps
`default_nettype none
module tidu_core_asserts #(
    parameter int ADDR_W  = 24,
    parameter int COUNT_W = 16
) (
    input wire logic               mclk,
    input wire logic               rst,
    input wire logic               info_load,
    input wire logic               xfer_done,
    input wire logic               info_ready,
    input wire logic               size_word,
    input wire logic [1:0]         mode_eff,
    input wire logic               wb_valid,
    input wire logic [ADDR_W-1:0]  wb_source_address,
    input wire logic [ADDR_W-1:0]  wb_destination_address,
    input wire logic [COUNT_W-1:0] wb_count_primary,
    input wire logic               chain_fetch,
    input wire logic               finish_wait,
    input wire logic               seq_end,
    input wire logic               clear_source_flag,
    input wire logic               clear_activation_enable
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    AST_LOAD_READY: assert property (info_load && !info_ready |=> info_ready)
        else $error("load not acknowledged");
    AST_DONE_WB: assert property (info_ready && xfer_done |=> wb_valid && !info_ready)
        else $error("write-back missing after done");
    AST_WB_PULSE: assert property (wb_valid |=> !wb_valid)
        else $error("write-back longer than one cycle");
    AST_ONE_EXIT: assert property (wb_valid |-> chain_fetch != finish_wait)
        else $error("chain and finish not exclusive");
    AST_CHAIN_QUIET: assert property (chain_fetch |-> !(seq_end || clear_source_flag
        || clear_activation_enable))
        else $error("chained transfer touched flags");
    AST_FLAG_KEEP: assert property (clear_source_flag |-> finish_wait && !seq_end)
        else $error("source flag cleared at end");
    AST_END_ENABLE: assert property (seq_end |-> finish_wait && clear_activation_enable)
        else $error("end without enable clear");
    AST_SRC_STEP: assert property (wb_valid && mode_eff == 2'h0 && size_word |->
        (wb_source_address - $past(wb_source_address)) inside {24'h00_0000,
        24'h00_0002, 24'hFF_FFFE})
        else $error("bad source word step");
    AST_DST_STEP: assert property (wb_valid && mode_eff == 2'h0 && !size_word |->
        (wb_destination_address - $past(wb_destination_address)) inside
        {24'h00_0000, 24'h00_0001, 24'hFF_FFFF})
        else $error("bad destination byte step");
    AST_NORM_COUNT: assert property (wb_valid && mode_eff == 2'h0 |->
        wb_count_primary == $past(wb_count_primary) - 16'h0001)
        else $error("normal count not decremented");
    AST_MODE_CODE: assert property (mode_eff != 2'h3)
        else $error("unassigned mode shown");
endmodule
bind tidu_core tidu_core_asserts #(.ADDR_W(ADDR_W), .COUNT_W(COUNT_W)) tidu_core_asserts_inst (
    .mclk                    (mclk),
    .rst                     (rst),
    .info_load               (info_load),
    .xfer_done               (xfer_done),
    .info_ready              (info_ready),
    .size_word               (size_word),
    .mode_eff                (mode_eff),
    .wb_valid                (wb_valid),
    .wb_source_address       (wb_source_address),
    .wb_destination_address  (wb_destination_address),
    .wb_count_primary        (wb_count_primary),
    .chain_fetch             (chain_fetch),
    .finish_wait             (finish_wait),
    .seq_end                 (seq_end),
    .clear_source_flag       (clear_source_flag),
    .clear_activation_enable (clear_activation_enable)
);
`default_nettype wire

// ---- sim/tidu_core_tb_top.sv ----
// Purpose: self-checking bench for the transfer-information update block
// Assumes: ram model fetches; bench works out every write-back itself
// Notes:   all mode byte a values swept, then random sets
`timescale 1ns/100ps
`default_nettype none
module tidu_core_tb_top;
    logic mclk, rst, go, info_load, xfer_done, info_ready, size_word, side, wb_valid;
    logic chain_fetch, finish_wait, seq_end, clr_flag, clr_en;
    logic [95:0] set_in, set_bus;
    logic [3:0] dly;
    logic [1:0] mode_eff;
    logic [23:0] wb_src, wb_dst;
    logic [15:0] wb_ca, wb_cb;
    int failures = 0, cmp_count = 0, cyc = 0;
    tidu_ram_model tidu_ram_model_inst (.mclk(mclk), .rst(rst), .go(go), .set_in(set_in),
        .dly(dly), .info_ready(info_ready), .info_load(info_load), .set_out(set_bus),
        .xfer_done(xfer_done));
    tidu_core tidu_core_inst (.mclk(mclk), .rst(rst), .info_load(info_load),
        .transfer_mode_byte_a(set_bus[95:88]), .transfer_mode_byte_b(set_bus[87:80]),
        .source_address(set_bus[79:56]), .destination_address(set_bus[55:32]),
        .transfer_count_primary(set_bus[31:16]), .transfer_count_block(set_bus[15:0]),
        .xfer_done(xfer_done), .info_ready(info_ready), .size_word(size_word),
        .repeat_area_is_source(side), .mode_eff(mode_eff), .wb_valid(wb_valid),
        .wb_source_address(wb_src), .wb_destination_address(wb_dst),
        .wb_count_primary(wb_ca), .wb_count_block(wb_cb), .chain_fetch(chain_fetch),
        .finish_wait(finish_wait), .seq_end(seq_end), .clear_source_flag(clr_flag),
        .clear_activation_enable(clr_en));
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    function automatic logic [85:0] expect_wb(input logic [95:0] s);
        logic [7:0] a, b, lo;
        logic [23:0] sa, da, ds, dd;
        logic [15:0] ca, cb;
        logic [8:0] n;
        logic [1:0] md;
        logic wrap, se;
        {a, b, sa, da, ca, cb} = s;
        md = (a[3:2] == 2'h3) ? 2'h0 : a[3:2];
        ds = a[7] ? (a[0] ? 24'h00_0002 : 24'h00_0001) : 24'h00_0000;
        dd = a[5] ? (a[0] ? 24'h00_0002 : 24'h00_0001) : 24'h00_0000;
        if (a[6]) ds = -ds;
        if (a[4]) dd = -dd;
        lo = ca[7:0] - 8'h01;
        wrap = (md != 2'h0) && lo == 8'h00;
        n = (ca[15:8] == 8'h00) ? 9'h100 : {1'b0, ca[15:8]};
        se = 1'b0;
        if (md == 2'h0) begin
            ca = ca - 16'h0001;
            se = ca == 16'h0000;
        end else begin
            ca = {ca[15:8], wrap ? ca[15:8] : lo};
            if (md == 2'h2 && wrap) begin
                cb = cb - 16'h0001;
                se = cb == 16'h0000;
            end
        end
        sa = sa + ds - ((wrap && a[1]) ? ds * {15'h0000, n} : 24'h00_0000);
        da = da + dd - ((wrap && !a[1]) ? dd * {15'h0000, n} : 24'h00_0000);
        se = se && !b[7];
        return {md, sa, da, ca, cb, se, !b[7] && !b[6] && !se, !b[7] && (se || b[6]), b[7]};
    endfunction
    task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic run_set(input logic [95:0] s, input logic [3:0] d);
        logic [85:0] e;
        int k;
        e = expect_wb(s);
        k = 0;
        set_in <= s;
        dly <= d;
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
        do begin
            @(posedge mclk);
            #1;
            k++;
        end while (wb_valid !== 1'b1 && k < 40);
        check("wb_valid", 24'h00_0001, {23'h00_0000, wb_valid});
        check("info_ready", 24'h00_0000, {23'h00_0000, info_ready});
        check("src", e[83:60], wb_src);
        check("dst", e[59:36], wb_dst);
        check("count_a", {8'h00, e[35:20]}, {8'h00, wb_ca});
        check("count_b", {8'h00, e[19:4]}, {8'h00, wb_cb});
        check("flags", {20'h0_0000, e[3:0]}, {20'h0_0000, seq_end, clr_flag, clr_en,
            chain_fetch});
        check("finish", {23'h00_0000, !e[0]}, {23'h00_0000, finish_wait});
        check("decode", {20'h0_0000, e[85:84], s[89:88]}, {20'h0_0000, mode_eff, side,
            size_word});
        @(posedge mclk);
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            end_of_test();
        end
    end
    initial begin
        logic [95:0] s;
        rst = 1'b1;
        go = 1'b0;
        set_in = 96'h0;
        dly = 4'h0;
        void'($urandom(71));
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        for (int i = 0; i < 256; i++) begin
            s = {i[7:0], i[1] ^ i[4], i[2], 6'h00, 24'hFF_FFFE, 24'h00_0000,
                (i % 3 == 0) ? 16'h0001 : ((i % 3 == 1) ? 16'h0000 : 16'h0201), 16'h0001};
            run_set(s, i[3:0] % 4'h4);
        end
        for (int i = 0; i < 80; i++) begin
            s = {$urandom, $urandom, $urandom};
            s[85:80] = 6'h00;
            s[57:56] = s[88] ? 2'h0 : s[57:56];
            s[33:32] = s[88] ? 2'h0 : s[33:32];
            s[23:16] = 8'($urandom % 3);
            s[15:0] = 16'($urandom % 3);
            run_set(s, 4'($urandom % 5));
        end
        end_of_test();
    end
endmodule
`default_nettype wire

// ---- sim/tidu_ram_model.sv ----
// Purpose: on-chip ram and sequencer side that fetches sets and ends transfers
// Assumes: bench places the set; model hands it over in one cycle
// Notes:   bus toggles between fetches so stale values never look valid
`timescale 1ns/100ps
`default_nettype none
module tidu_ram_model (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        go,
    input  wire logic [95:0] set_in,
    input  wire logic [3:0]  dly,
    input  wire logic        info_ready,
    output logic             info_load,
    output logic      [95:0] set_out,
    output logic             xfer_done
);
    logic [3:0] cnt;
    always_ff @(posedge mclk) begin
        info_load <= go && !rst;
        set_out   <= go ? set_in : ~set_out;
        xfer_done <= !rst && info_ready && !xfer_done && cnt == dly;
        cnt       <= (info_ready && !xfer_done) ? cnt + 4'h1 : 4'h0;
    end
endmodule
`default_nettype wire
